// File: mmu_ctl_pkg.sv
package mmu_ctl_pkg;

  // widths and counts
  localparam int XLEN      = 32;
  localparam int SEG_COUNT = 16;
  localparam int SEG_SEL_W = 4;
  localparam int SPR_W     = 5;
  localparam int BAT_COUNT = 16;

  // segment selection field of the index register, big-endian bits 0-3
  localparam int SEL_MSB   = 31;
  localparam int SEL_LSB   = 28;
  // big-endian bit 0 of a segment descriptor selects its format
  localparam int SEG_T_BIT = 31;

  // special register select: 0..7 instruction block pairs, 8..15 data pairs
  localparam logic [SPR_W-1:0] SPR_BAT_LAST = 5'h0F;
  localparam logic [SPR_W-1:0] SPR_PT_BASE  = 5'h10;

  // reset values
  localparam logic [XLEN-1:0] SEG_RESET = 32'h0000_0000;
  localparam logic [XLEN-1:0] BAT_RESET = 32'h0000_0000;
  localparam logic [XLEN-1:0] PTB_RESET = 32'h0000_0000;

  // memory attribute bits for real addressing, and the value used for translated accesses
  localparam logic [3:0] ATTR_REAL_DATA     = 4'h3;
  localparam logic [3:0] ATTR_REAL_INSTR_CO = 4'h3;
  localparam logic [3:0] ATTR_REAL_INSTR_NC = 4'h1;
  localparam logic [3:0] ATTR_TRANSLATED    = 4'h0;

  typedef enum logic [3:0] {
    op_none,
    op_mtsr,
    op_mtsrin,
    op_mfsr,
    op_mfsrin,
    op_mtspr,
    op_mfspr,
    op_tlbia,
    op_tlbie,
    op_tlbsync,
    op_ext_ctl
  } mmu_op_t;

endpackage

// File: seg_reg_file.sv
module seg_reg_file
  import mmu_ctl_pkg::*;
#(
  parameter int DEPTH = SEG_COUNT,
  parameter int WIDTH = XLEN
) (
  // clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset_n,
  // write port
  input  wire logic                     i_wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] i_wr_sel,
  input  wire logic [WIDTH-1:0]         i_wr_data,
  // read port, data one cycle after i_rd_en
  input  wire logic                     i_rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_sel,
  output logic      [WIDTH-1:0]         o_rd_data
);

  if (DEPTH < 2) begin : g_bad_depth
    $error("seg_reg_file: DEPTH must be at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rd_next;

  always_comb begin
    rd_next = o_rd_data;
    if (i_rd_en) begin
      rd_next = mem_reg[i_rd_sel];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= '0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= SEG_RESET;
      end
    end else begin
      o_rd_data <= rd_next;
      if (i_wr_en) begin
        mem_reg[i_wr_sel] <= i_wr_data;
      end
    end
  end

endmodule

// File: tlb_valid_array.sv
module tlb_valid_array #(
  parameter int ENTRIES = 16,
  parameter int AW      = 32,
  parameter int PAGE_W  = 12
) (
  // clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_reset_n,
  // fill from the table walker
  input  wire logic          i_fill,
  input  wire logic [AW-1:0] i_fill_ea,
  // local and peer single invalidations, whole flush
  input  wire logic          i_inval_a,
  input  wire logic [AW-1:0] i_inval_a_ea,
  input  wire logic          i_inval_b,
  input  wire logic [AW-1:0] i_inval_b_ea,
  input  wire logic          i_class_purge,
  input  wire logic          i_inval_all,
  // lookup, hit one cycle later
  input  wire logic [AW-1:0] i_lookup_ea,
  output logic               o_hit
);

  localparam int IW = $clog2(ENTRIES);
  localparam int TW = AW - PAGE_W - IW;

  if (TW < 1 || ENTRIES < 2) begin : g_bad_geom
    $error("tlb_valid_array: geometry leaves no tag");
  end

  logic [ENTRIES-1:0] valid_reg;
  logic [ENTRIES-1:0] valid_next;
  logic [TW-1:0]      tag_reg  [ENTRIES];
  logic [TW-1:0]      tag_next [ENTRIES];
  logic               hit_next;

  function automatic logic [IW-1:0] idx(input logic [AW-1:0] ea);
    return ea[PAGE_W +: IW];
  endfunction

  function automatic logic [TW-1:0] tag(input logic [AW-1:0] ea);
    return ea[AW-1 -: TW];
  endfunction

  always_comb begin
    valid_next = valid_reg;
    tag_next   = tag_reg;
    if (i_fill) begin
      valid_next[idx(i_fill_ea)] = 1'b1;
      tag_next[idx(i_fill_ea)]   = tag(i_fill_ea);
    end
    // invalidation wins over a same-cycle fill of the entry when the stored tag matches or a class purge is set
    for (int k = 0; k < ENTRIES; k++) begin
      if (i_inval_a && idx(i_inval_a_ea) == k[IW-1:0]
          && (i_class_purge || tag_reg[k] == tag(i_inval_a_ea))) begin
        valid_next[k] = 1'b0;
      end
      if (i_inval_b && idx(i_inval_b_ea) == k[IW-1:0]
          && (i_class_purge || tag_reg[k] == tag(i_inval_b_ea))) begin
        valid_next[k] = 1'b0;
      end
    end
    if (i_inval_all) begin
      valid_next = '0;
    end
    hit_next = valid_reg[idx(i_lookup_ea)]
               && tag_reg[idx(i_lookup_ea)] == tag(i_lookup_ea);
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      valid_reg <= '0;
      o_hit     <= 1'b0;
      for (int k = 0; k < ENTRIES; k++) begin
        tag_reg[k] <= '0;
      end
    end else begin
      valid_reg <= valid_next;
      tag_reg   <= tag_next;
      o_hit     <= hit_next;
    end
  end

endmodule

// File: mmu_control.sv
// Functional notes
// RULE_01 - segment move-to writes direct or indirect register
// RULE_02 - segment move-from reads direct or indirect register
// RULE_03 - invalidate-all clears every entry, local only
// RULE_04 - invalidate-entry clears hit entry on all processors
// RULE_05 - synchronize waits for own invalidations everywhere
// RULE_06 - provide single-entry and whole-TLB invalidation
// RULE_07 - invalidate-entry may purge whole congruence class
// RULE_08 - invalidations may signal peers in hardware
// RULE_09 - unimplemented optional op: no-op or illegal
// RULE_10 - MMU registers reachable by supervisor only
// RULE_11 - sixteen 32-bit segment registers, bit 0 format
// RULE_12 - sixteen 32-bit block translation registers
// RULE_13 - 32-bit page table base register
// RULE_14 - translation off: effective address is physical
// RULE_15 - surplus high address bits may be dropped
// RULE_16 - real mode skips protection and history recording
// RULE_17 - real-mode data attributes are 0b0011
// RULE_18 - real-mode fetch attributes 0b0001 or 0b0011
// RULE_19 - any exception clears both translation enables
// RULE_20 - external-control ops undefined with data translation off
// RULE_21 - each enable governs its own access type
// RULE_22 - invalidations never touch block translation registers
module mmu_control
#(
  parameter int         PA_WIDTH       = 32,
  parameter int         TLB_ENTRIES    = 16,
  parameter int         PAGE_W         = 12,
  parameter logic       TLBIA_PRESENT  = 1'b1,
  parameter logic       UNIMPL_ILLEGAL = 1'b1,
  parameter logic       CLASS_PURGE    = 1'b0,
  parameter logic       INSTR_COHERENT = 1'b1
) (
  // clock and reset
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_reset_n,
  // instruction issue from the pipeline
  input  wire logic                                i_op_valid,
  input  wire mmu_ctl_pkg::mmu_op_t                i_op,
  input  wire logic                                i_supervisor,
  input  wire logic [mmu_ctl_pkg::SEG_SEL_W-1:0]   i_seg_field,
  input  wire logic [mmu_ctl_pkg::SPR_W-1:0]       i_spr_index,
  input  wire logic [mmu_ctl_pkg::XLEN-1:0]        i_source_gpr,
  input  wire logic [mmu_ctl_pkg::XLEN-1:0]        i_index_gpr,
  output logic                                     o_op_ready,
  output logic                                     o_op_done,
  output logic      [mmu_ctl_pkg::XLEN-1:0]        o_result,
  output logic                                     o_seg_direct_store,
  output logic                                     o_illegal,
  output logic                                     o_priv_fault,
  output logic                                     o_ext_ctl_undefined,
  // machine state translation enables
  input  wire logic                                i_msr_write,
  input  wire logic                                i_instr_translate_enable,
  input  wire logic                                i_data_translate_enable,
  input  wire logic                                i_exception,
  output logic                                     o_instr_translate_enable,
  output logic                                     o_data_translate_enable,
  // TLB fill and lookup
  input  wire logic                                i_tlb_fill,
  input  wire logic [mmu_ctl_pkg::XLEN-1:0]        i_tlb_fill_ea,
  input  wire logic [mmu_ctl_pkg::XLEN-1:0]        i_tlb_lookup_ea,
  output logic                                     o_tlb_hit,
  // invalidation signalling to and from peers
  output logic                                     o_inval_req,
  output logic      [mmu_ctl_pkg::XLEN-1:0]        o_inval_ea,
  input  wire logic                                i_inval_ack,
  input  wire logic                                i_peer_inval,
  input  wire logic [mmu_ctl_pkg::XLEN-1:0]        i_peer_inval_ea,
  // instruction fetch address path
  input  wire logic                                i_fetch_valid,
  input  wire logic [mmu_ctl_pkg::XLEN-1:0]        i_fetch_ea,
  output logic                                     o_fetch_real,
  output logic      [PA_WIDTH-1:0]                 o_fetch_pa,
  output logic      [3:0]                          o_fetch_attr,
  // data access address path
  input  wire logic                                i_data_valid,
  input  wire logic [mmu_ctl_pkg::XLEN-1:0]        i_data_ea,
  output logic                                     o_data_real,
  output logic      [PA_WIDTH-1:0]                 o_data_pa,
  output logic      [3:0]                          o_data_attr,
  // page table base contents for the translator
  output logic      [mmu_ctl_pkg::XLEN-1:0]        o_page_table_base
);

  import mmu_ctl_pkg::*;

  if (PA_WIDTH < 1 || PA_WIDTH > XLEN) begin : g_bad_pa
    $error("mmu_control: PA_WIDTH out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state
  typedef enum {st_idle, st_read, st_sync} ctl_state_t;
  ctl_state_t       state_reg,   state_next;
  logic             done_reg,    done_next,    illegal_reg, illegal_next;
  logic             priv_reg,    priv_next,    ext_reg,     ext_next;
  logic             tbit_reg,    tbit_next,    pend_reg,    pend_next;
  logic [XLEN-1:0]  result_reg,  result_next;
  logic [XLEN-1:0]  pend_ea_reg, pend_ea_next;
  logic [XLEN-1:0]  instr_block_xlate_reg [BAT_COUNT/2];
  logic [XLEN-1:0]  data_block_xlate_reg  [BAT_COUNT/2];
  logic [XLEN-1:0]  iblk_next [BAT_COUNT/2];
  logic [XLEN-1:0]  dblk_next [BAT_COUNT/2];
  logic [XLEN-1:0]  page_table_base_reg, ptb_next;

  logic                 take, seg_op, spr_op, seg_we, seg_re;
  logic                 inval_local, inval_all, spr_is_bat;
  logic [SEG_SEL_W-1:0] seg_sel;
  logic [XLEN-1:0]      seg_rd_data;
  logic [2:0]           bat_slot;

  // a second invalidate waits until peers acknowledged the first
  assign o_op_ready = (state_reg == st_idle) && !(pend_reg && i_op == op_tlbie);
  assign take       = i_op_valid && o_op_ready;
  assign seg_op     = i_op inside {op_mtsr, op_mtsrin, op_mfsr, op_mfsrin};
  assign spr_op     = i_op inside {op_mtspr, op_mfspr};
  assign seg_sel    = (i_op == op_mtsrin || i_op == op_mfsrin)
                      ? i_index_gpr[SEL_MSB:SEL_LSB] : i_seg_field; // RULE_01 RULE_02
  assign seg_we     = take && i_supervisor
                      && (i_op == op_mtsr || i_op == op_mtsrin); // RULE_01 RULE_10
  assign seg_re     = take && i_supervisor
                      && (i_op == op_mfsr || i_op == op_mfsrin); // RULE_02 RULE_10
  assign inval_local = take && i_op == op_tlbie; // RULE_04 RULE_06
  assign inval_all   = take && i_op == op_tlbia && TLBIA_PRESENT; // RULE_03 RULE_06
  assign spr_is_bat  = i_spr_index <= SPR_BAT_LAST;
  assign bat_slot    = i_spr_index[2:0];

  always_comb begin
    state_next   = state_reg;
    done_next    = 1'b0;
    result_next  = result_reg;
    tbit_next    = tbit_reg;
    illegal_next = 1'b0;
    priv_next    = 1'b0;
    ext_next     = 1'b0;
    pend_next    = pend_reg;
    pend_ea_next = pend_ea_reg;
    iblk_next    = instr_block_xlate_reg;
    dblk_next    = data_block_xlate_reg;
    ptb_next     = page_table_base_reg;
    if (pend_reg && i_inval_ack) begin
      pend_next = 1'b0;
    end
    case (state_reg)
      st_idle: begin
        if (take) begin
          done_next = 1'b1;
          if ((seg_op || spr_op) && !i_supervisor) begin
            priv_next = 1'b1; // RULE_10
          end else if (seg_re) begin
            done_next  = 1'b0;
            state_next = st_read;
          end else if (spr_op && !spr_is_bat && i_spr_index != SPR_PT_BASE) begin
            illegal_next = 1'b1;
          end else if (i_op == op_mtspr) begin
            if (!spr_is_bat) begin
              ptb_next = i_source_gpr; // RULE_13
            end else if (i_spr_index[3]) begin
              dblk_next[bat_slot] = i_source_gpr; // RULE_12
            end else begin
              iblk_next[bat_slot] = i_source_gpr; // RULE_12
            end
          end else if (i_op == op_mfspr) begin
            result_next = !spr_is_bat ? page_table_base_reg
                          : i_spr_index[3] ? data_block_xlate_reg[bat_slot]
                          : instr_block_xlate_reg[bat_slot];
          end else if (i_op == op_tlbia && !TLBIA_PRESENT) begin
            illegal_next = UNIMPL_ILLEGAL; // RULE_09
          end else if (i_op == op_tlbie) begin
            pend_next    = 1'b1; // RULE_08 RULE_04
            pend_ea_next = i_index_gpr;
          end else if (i_op == op_tlbsync) begin
            done_next  = 1'b0;
            state_next = st_sync;
          end else if (i_op == op_ext_ctl) begin
            ext_next = !o_data_translate_enable; // RULE_20
          end
        end
      end
      st_read: begin
        result_next = seg_rd_data; // RULE_02
        tbit_next   = seg_rd_data[SEG_T_BIT]; // RULE_11
        done_next   = 1'b1;
        state_next  = st_idle;
      end
      st_sync: begin
        // completes only once no invalidation is still out at the peers
        if (!pend_reg || i_inval_ack) begin
          done_next  = 1'b1; // RULE_05
          state_next = st_idle;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg           <= st_idle;
      done_reg            <= 1'b0;
      result_reg          <= '0;
      tbit_reg            <= 1'b0;
      illegal_reg         <= 1'b0;
      priv_reg            <= 1'b0;
      ext_reg             <= 1'b0;
      pend_reg            <= 1'b0;
      pend_ea_reg         <= '0;
      page_table_base_reg <= PTB_RESET;
      for (int k = 0; k < BAT_COUNT/2; k++) begin
        instr_block_xlate_reg[k] <= BAT_RESET;
        data_block_xlate_reg[k]  <= BAT_RESET;
      end
    end else begin
      state_reg             <= state_next;
      done_reg              <= done_next;
      result_reg            <= result_next;
      tbit_reg              <= tbit_next;
      illegal_reg           <= illegal_next;
      priv_reg              <= priv_next;
      ext_reg               <= ext_next;
      pend_reg              <= pend_next;
      pend_ea_reg           <= pend_ea_next;
      page_table_base_reg   <= ptb_next;
      instr_block_xlate_reg <= iblk_next;
      data_block_xlate_reg  <= dblk_next;
    end
  end

  assign o_op_done           = done_reg;
  assign o_result            = result_reg;
  assign o_seg_direct_store  = tbit_reg;
  assign o_illegal           = illegal_reg;
  assign o_priv_fault        = priv_reg;
  assign o_ext_ctl_undefined = ext_reg;
  assign o_inval_req         = pend_reg; // RULE_08
  assign o_inval_ea          = pend_ea_reg;
  assign o_page_table_base   = page_table_base_reg;

  ////////////////////////////////////////////////////////////////////////////
  // segment registers and TLB valid array
  seg_reg_file #(
    .DEPTH (SEG_COUNT),
    .WIDTH (XLEN)
  ) u_segment_descriptor_reg (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_wr_en   (seg_we),
    .i_wr_sel  (seg_sel),
    .i_wr_data (i_source_gpr),
    .i_rd_en   (seg_re),
    .i_rd_sel  (seg_sel),
    .o_rd_data (seg_rd_data)
  ); // RULE_11

  // block registers live outside this array, so no flush reaches them
  tlb_valid_array #(
    .ENTRIES (TLB_ENTRIES),
    .AW      (XLEN),
    .PAGE_W  (PAGE_W)
  ) u_tlb (
    .i_clk_sys     (i_clk_sys),
    .i_reset_n     (i_reset_n),
    .i_fill        (i_tlb_fill),
    .i_fill_ea     (i_tlb_fill_ea),
    .i_inval_a     (inval_local),
    .i_inval_a_ea  (i_index_gpr),
    .i_inval_b     (i_peer_inval),
    .i_inval_b_ea  (i_peer_inval_ea),
    .i_class_purge (CLASS_PURGE),
    .i_inval_all   (inval_all),
    .i_lookup_ea   (i_tlb_lookup_ea),
    .o_hit         (o_tlb_hit)
  ); // RULE_03 RULE_04 RULE_07 RULE_22

  ////////////////////////////////////////////////////////////////////////////
  // translation enables and real addressing
  logic                ir_reg,     ir_next,     dr_reg,     dr_next;
  logic                f_real_reg, f_real_next, d_real_reg, d_real_next;
  logic [PA_WIDTH-1:0] f_pa_reg,   f_pa_next,   d_pa_reg,   d_pa_next;
  logic [3:0]          f_attr_reg, f_attr_next, d_attr_reg, d_attr_next;

  always_comb begin
    ir_next = ir_reg;
    dr_next = dr_reg;
    if (i_msr_write) begin
      ir_next = i_instr_translate_enable;
      dr_next = i_data_translate_enable;
    end
    // exception entry overrides a same-cycle state write
    if (i_exception) begin
      ir_next = 1'b0; // RULE_19
      dr_next = 1'b0; // RULE_19
    end
    f_real_next = i_fetch_valid && !ir_reg; // RULE_21 RULE_16
    d_real_next = i_data_valid && !dr_reg; // RULE_21 RULE_16
    f_pa_next   = i_fetch_ea[PA_WIDTH-1:0]; // RULE_14 RULE_15
    d_pa_next   = i_data_ea[PA_WIDTH-1:0]; // RULE_14 RULE_15
    f_attr_next = !ir_reg ? (INSTR_COHERENT ? ATTR_REAL_INSTR_CO : ATTR_REAL_INSTR_NC)
                          : ATTR_TRANSLATED; // RULE_18
    d_attr_next = !dr_reg ? ATTR_REAL_DATA : ATTR_TRANSLATED; // RULE_17
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ir_reg     <= 1'b0; // RULE_19
      dr_reg     <= 1'b0;
      f_real_reg <= 1'b0;
      d_real_reg <= 1'b0;
      f_pa_reg   <= '0;
      d_pa_reg   <= '0;
      f_attr_reg <= ATTR_TRANSLATED;
      d_attr_reg <= ATTR_TRANSLATED;
    end else begin
      ir_reg     <= ir_next;
      dr_reg     <= dr_next;
      f_real_reg <= f_real_next;
      d_real_reg <= d_real_next;
      f_pa_reg   <= f_pa_next;
      d_pa_reg   <= d_pa_next;
      f_attr_reg <= f_attr_next;
      d_attr_reg <= d_attr_next;
    end
  end

  assign o_instr_translate_enable = ir_reg;
  assign o_data_translate_enable  = dr_reg;
  assign o_fetch_real = f_real_reg;
  assign o_fetch_pa   = f_pa_reg;
  assign o_fetch_attr = f_attr_reg;
  assign o_data_real  = d_real_reg;
  assign o_data_pa    = d_pa_reg;
  assign o_data_attr  = d_attr_reg;

endmodule

// File: mmu_checker.sv
module mmu_checker
  import mmu_ctl_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  input wire logic        i_op_valid,
  input wire mmu_op_t     i_op,
  input wire logic        i_supervisor,
  input wire logic [31:0] i_index_gpr,
  input wire logic        o_op_ready,
  input wire logic        o_op_done,
  input wire logic        o_priv_fault,
  input wire logic        i_exception,
  input wire logic        o_instr_translate_enable,
  input wire logic        o_data_translate_enable,
  input wire logic        i_fetch_valid,
  input wire logic        o_fetch_real,
  input wire logic [3:0]  o_fetch_attr,
  input wire logic        i_data_valid,
  input wire logic        o_data_real,
  input wire logic [3:0]  o_data_attr,
  input wire logic        o_inval_req,
  input wire logic [31:0] o_inval_ea,
  input wire logic        i_inval_ack
);
  wire logic take = i_op_valid && o_op_ready;
  // a sync stays outstanding until its own done pulse
  logic      sync_reg;
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
    if (!i_reset_n) sync_reg <= 1'b0;
    else sync_reg <= (sync_reg && !o_op_done) || (take && i_op == op_tlbsync);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////
  AST_EXC_REAL: assert property (i_exception |=>
    !o_instr_translate_enable && !o_data_translate_enable) else $error("enable kept");
  AST_DATA_ATTR: assert property (i_data_valid && !o_data_translate_enable |=>
    o_data_real && o_data_attr == 4'h3) else $error("data attr");
  AST_FETCH_ATTR: assert property (i_fetch_valid && !o_instr_translate_enable |=>
    o_fetch_real && o_fetch_attr inside {4'h1, 4'h3}) else $error("fetch attr");
  AST_OWN_ENABLE: assert property (i_fetch_valid && o_instr_translate_enable |=>
    !o_fetch_real) else $error("fetch real while translating");
  AST_INVAL_OUT: assert property (take && i_supervisor && i_op == op_tlbie |=>
    o_inval_req && o_inval_ea == $past(i_index_gpr)) else $error("no peer request");
  AST_INVAL_HOLD: assert property (o_inval_req && !i_inval_ack |=>
    o_inval_req && $stable(o_inval_ea)) else $error("request dropped");
  AST_SYNC_WAIT: assert property (sync_reg && o_inval_req |->
    !o_op_done) else $error("sync done early");
  AST_SYNC_END: assert property (take && i_op == op_tlbsync |->
    ##[1:40] o_op_done) else $error("sync hangs");
  AST_USER_REFUSED: assert property (take && !i_supervisor && i_op inside
    {op_mtsr, op_mtsrin, op_mfsr, op_mfsrin, op_mtspr, op_mfspr} |->
    ##[1:2] (o_op_done && o_priv_fault)) else $error("user access taken");
endmodule

bind mmu_control mmu_checker u_chk (.*);

// File: peer_tlb_model.sv
module peer_tlb_model (
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_req,
  input  wire logic i_slow,
  output logic      o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  ////////////////////////////////////////////////////////////////////////////
  // peers purge after a short or a long delay; ack is a one-cycle pulse
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 4'h0;
      o_ack   <= 1'b0;
    end else if (o_ack) begin
      cnt_reg <= 4'h0;
      o_ack   <= 1'b0;
    end else if (i_req) begin
      cnt_reg <= cnt_reg + 4'h1;
      o_ack   <= (cnt_reg == (i_slow ? 4'h9 : 4'h1));
    end
  end
endmodule

// File: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mmu_ctl_pkg::*;
  logic        clk, rst_n, op_valid, sup, msr_write, instr_translate_enable, data_translate_enable, exc, fill, pinv;
  logic        f_valid, d_valid, ack, slow, ready, done, sds, ill, priv, ecu, ir_en, dr_en;
  logic        hit, req, f_real, d_real;
  mmu_op_t     op;
  logic [3:0]  seg, f_attr, d_attr;
  logic [4:0]  spr;
  logic [31:0] src, idx, fill_ea, look_ea, peer_ea, f_ea, d_ea, res, iea, f_pa, d_pa, ptb;
  int          n_fail, comparisons;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  mmu_control uut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_op_valid(op_valid), .i_op(op),
    .i_supervisor(sup), .i_seg_field(seg), .i_spr_index(spr), .i_source_gpr(src),
    .i_index_gpr(idx), .o_op_ready(ready), .o_op_done(done), .o_result(res),
    .o_seg_direct_store(sds), .o_illegal(ill), .o_priv_fault(priv),
    .o_ext_ctl_undefined(ecu), .i_msr_write(msr_write), .i_instr_translate_enable(instr_translate_enable),
    .i_data_translate_enable(data_translate_enable), .i_exception(exc), .o_instr_translate_enable(ir_en),
    .o_data_translate_enable(dr_en), .i_tlb_fill(fill), .i_tlb_fill_ea(fill_ea),
    .i_tlb_lookup_ea(look_ea), .o_tlb_hit(hit), .o_inval_req(req), .o_inval_ea(iea),
    .i_inval_ack(ack), .i_peer_inval(pinv), .i_peer_inval_ea(peer_ea),
    .i_fetch_valid(f_valid), .i_fetch_ea(f_ea), .o_fetch_real(f_real), .o_fetch_pa(f_pa),
    .o_fetch_attr(f_attr), .i_data_valid(d_valid), .i_data_ea(d_ea), .o_data_real(d_real),
    .o_data_pa(d_pa), .o_data_attr(d_attr), .o_page_table_base(ptb));
  peer_tlb_model peer (.i_clk_sys(clk), .i_reset_n(rst_n), .i_req(req), .i_slow(slow),
    .o_ack(ack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // w=0 waits for ready, w=1 for done; a hang ends the run
  task automatic await(int w);
    for (int k = 0; (w ? done : ready) !== 1'b1; k++) begin
      @(negedge clk);
      if (k > 60) begin
        n_fail++;
        end_sim();
      end
    end
  endtask
  // direct segment field mirrors index bits 31:28 so both forms hit one register
  task automatic run(mmu_op_t o, logic s, logic [4:0] p, logic [31:0] d, logic [31:0] x);
    op = o;
    sup = s;
    spr = p;
    src = d;
    idx = x;
    seg = x[31:28];
    op_valid = 1'b1;
    await(0);
    @(negedge clk);
    op_valid = 1'b0;
    await(1);
  endtask
  task automatic look(logic [31:0] a, logic e);
    look_ea = a;
    @(negedge clk);
    chk("hit", {31'h0, hit}, {31'h0, e});
  endtask
  task automatic load(logic [31:0] a);
    fill = 1'b1;
    fill_ea = a;
    @(negedge clk);
    fill = 1'b0;
  endtask
  task automatic t_real();
    chk("enables", {ir_en, dr_en}, 32'h0);
    {d_valid, f_valid, d_ea, f_ea} = {2'h3, 32'hFEDC_BA98, 32'h0123_4567};
    @(negedge clk);
    chk("data pa", d_pa, d_ea);
    chk("fetch pa", f_pa, f_ea);
    chk("data attr", d_attr, 32'h3);
    chk("fetch attr", f_attr, 32'h3);
    {msr_write, instr_translate_enable, data_translate_enable} = 3'h6;
    @(negedge clk);
    msr_write = 1'b0;
    @(negedge clk);
    chk("real", {f_real, d_real, f_attr, d_attr}, {22'h0, 10'h103});
    run(op_ext_ctl, 1'b1, 5'h0, 32'h0, 32'h0);
    chk("ext", ecu, 32'h1);
    {msr_write, instr_translate_enable, data_translate_enable, exc} = 4'hF;
    @(negedge clk);
    {msr_write, exc} = 2'h0;
    @(negedge clk);
    chk("after exc", {ir_en, dr_en, d_real}, 32'h1);
  endtask
  task automatic t_seg();
    for (int i = 0; i < 16; i++)
      run(i[0] ? op_mtsrin : op_mtsr, 1'b1, 5'h0, {i[0], 27'h0, i[3:0]}, {i[3:0], 28'h0});
    run(op_mtsr, 1'b0, 5'h0, 32'hFFFF_FFFF, 32'h3000_0000);
    chk("priv", priv, 32'h1);
    for (int i = 0; i < 16; i++) begin
      run(i[0] ? op_mfsr : op_mfsrin, 1'b1, 5'h0, 32'h0, {i[3:0], 28'h0});
      chk("seg", res, {i[0], 27'h0, i[3:0]});
      chk("format", sds, i[0]);
    end
    run(op_mfsr, 1'b0, 5'h0, 32'h0, 32'h2000_0000);
    chk("user priv", priv, 32'h1);
    chk("user read", res, 32'h8000_000F);
  endtask
  task automatic t_spr();
    for (int i = 0; i <= 16; i++)
      run(op_mtspr, 1'b1, i[4:0], ~i, 32'h0);
    run(op_mtspr, 1'b0, 5'h10, 32'h0, 32'h0);
    run(op_mtspr, 1'b1, 5'h11, 32'h0, 32'h0);
    chk("illegal", ill, 32'h1);
    for (int i = 0; i <= 16; i++) begin
      run(op_mfspr, 1'b1, i[4:0], 32'h0, 32'h0);
      chk("spr", res, ~i);
    end
    chk("table base", ptb, 32'hFFFF_FFEF);
  endtask
  task automatic t_tlb();
    load(32'h0000_3000);
    load(32'h0000_5000);
    look(32'h0000_3000, 1'b1);
    slow = 1'b1;
    run(op_tlbie, 1'b1, 5'h0, 32'h0, 32'h0000_3000);
    chk("req", req, 32'h1);
    chk("req ea", iea, 32'h0000_3000);
    look(32'h0000_3000, 1'b0);
    look(32'h0000_5000, 1'b1);
    run(op_tlbsync, 1'b1, 5'h0, 32'h0, 32'h0);
    chk("sync", req, 32'h0);
    {pinv, peer_ea} = {1'b1, 32'h0000_5000};
    @(negedge clk);
    pinv = 1'b0;
    look(32'h0000_5000, 1'b0);
    slow = 1'b0;
    run(op_tlbie, 1'b1, 5'h0, 32'h0, 32'h0000_7000);
    run(op_tlbie, 1'b1, 5'h0, 32'h0, 32'h0000_9000);
    chk("second", iea, 32'h0000_9000);
    run(op_tlbsync, 1'b1, 5'h0, 32'h0, 32'h0);
    load(32'h0000_3000);
    load(32'h0000_4000);
    run(op_tlbia, 1'b1, 5'h0, 32'h0, 32'h0);
    chk("local", req, 32'h0);
    look(32'h0000_3000, 1'b0);
    look(32'h0000_4000, 1'b0);
    run(op_mfspr, 1'b1, 5'h3, 32'h0, 32'h0);
    chk("block kept", res, 32'hFFFF_FFFC);
  endtask

  initial begin
    {op_valid, sup, msr_write, instr_translate_enable, data_translate_enable, exc, fill, pinv, f_valid, d_valid} = '0;
    {slow, seg, spr, src, idx, fill_ea, look_ea, peer_ea, f_ea, d_ea} = '0;
    op = op_none;
    n_fail = 0;
    comparisons = 0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_real();
    t_seg();
    t_spr();
    t_tlb();
    end_sim();
  end
endmodule
